// [sdram_control_input_decode.sv]
// Control-input front end: clock gating, power modes, command capture, lane masks
`timescale 1ns/1ps

module sdram_control_input_decode
  import sdram_ctrl_pkg::*;
#(
  parameter int DW = sdram_ctrl_pkg::DATA_W,
  parameter int CW = sdram_ctrl_pkg::COL_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Controller pins
  input wire logic clkEnable,
  input wire sdram_ctrl_pkg::ctrl_s ctrlPins,
  input wire logic lowLaneMask,
  input wire logic highLaneMask,
  // Array core status
  input wire logic allBanksIdle,
  input wire logic burstStart,
  input wire logic burstRead,
  input wire logic burstWrite,
  input wire logic [DW-1:0] coreReadData,
  // Decoded command
  output logic cmdValid,
  output sdram_ctrl_pkg::cmd_s cmdStrobes,
  // Clock gating state
  output sdram_ctrl_pkg::power_e powerMode,
  output logic receiversOn,
  output logic edgeActive,
  // Burst and data path
  output logic [CW-1:0] burstColumn,
  output logic [DW-1:0] dqOut,
  output logic [sdram_ctrl_pkg::LANES-1:0] dqOe,
  output logic [sdram_ctrl_pkg::LANES-1:0] writeKeep
);
  import sdram_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------
  logic awake;
  logic runEdge;
  logic burstBusy;
  cmd_s pinStrobes;
  logic refreshReq;
  logic [LANES-1:0] laneMask;
  power_e next_mode;

  // Receivers only listen in run or suspend; the low-power modes watch only the enable
  assign awake = (powerMode == MODE_RUN) || (powerMode == MODE_SUSPEND);
  // An edge only does work when the enable is sampled high at that edge
  assign runEdge = awake && clkEnable;
  assign burstBusy = burstRead || burstWrite;
  assign pinStrobes = cmd_s'(~{ctrlPins.rowStrobeN, ctrlPins.colStrobeN,
                               ctrlPins.writeStrobeN});
  assign refreshReq = !ctrlPins.chipSelectN && (pinStrobes == CMD_REFRESH);
  assign laneMask = {highLaneMask, lowLaneMask};

  // ----------------------------------------------------------------
  // Clock gating mode
  // ----------------------------------------------------------------
  // With the enable tied high every state below falls back to run
  always_comb begin
    next_mode = powerMode;
    case (powerMode)
      MODE_RUN, MODE_SUSPEND: begin
        if (clkEnable) begin
          next_mode = MODE_RUN;
        end else if (burstBusy) begin
          next_mode = MODE_SUSPEND;
        end else if (refreshReq) begin
          next_mode = MODE_SELF_REF;
        end else if (allBanksIdle) begin
          next_mode = MODE_PRE_PD;
        end else begin
          next_mode = MODE_ACT_PD;
        end
      end
      MODE_PRE_PD, MODE_ACT_PD, MODE_SELF_REF: begin
        // Clock receiver is off here, so the raw enable level alone wakes us
        if (clkEnable) begin
          next_mode = MODE_RUN;
        end
      end
      default: next_mode = MODE_RUN;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      powerMode <= MODE_RST;
      receiversOn <= 1'b1;
    end else begin
      powerMode <= next_mode;
      receiversOn <= (next_mode == MODE_RUN) || (next_mode == MODE_SUSPEND);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      edgeActive <= 1'b0;
    end else begin
      edgeActive <= runEdge;
    end
  end

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  // Select high masks only new commands; burst and mask paths do not look at it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmdValid <= 1'b0;
      cmdStrobes <= CMD_RST;
    end else begin
      cmdValid <= runEdge && !ctrlPins.chipSelectN;
      if (runEdge && !ctrlPins.chipSelectN) begin
        cmdStrobes <= pinStrobes;
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst column counter and output data register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      burstColumn <= '0;
    end else if (runEdge) begin
      if (burstStart) begin
        burstColumn <= '0;
      end else if (burstBusy) begin
        burstColumn <= burstColumn + CW'(1);
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dqOut <= '0;
    end else if (runEdge) begin
      dqOut <= coreReadData;
    end
  end

  // ----------------------------------------------------------------
  // Lane masks
  // ----------------------------------------------------------------
  lane_mask_pipe #(
    .NUM_LANES(LANES),
    .LATENCY(MASK_LATENCY)
  ) u_lane_mask (
    .clock(clock),
    .sys_rst(sys_rst),
    .advance(runEdge),
    .readActive(burstRead),
    .writeActive(burstWrite),
    .laneMask(laneMask),
    .writeKeep(writeKeep),
    .driveEnable(dqOe)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_read_masked_low;
    runEdge && burstRead && lowLaneMask;
  endsequence

  sequence s_stall_in_burst;
    awake && !clkEnable && burstBusy;
  endsequence

  sequence s_read_open_low;
    runEdge && burstRead && !lowLaneMask;
  endsequence

  sequence s_read_masked_high;
    runEdge && burstRead && highLaneMask;
  endsequence

  chk_select_enables: assert property (
    runEdge && !ctrlPins.chipSelectN |=> cmdValid)
    else $error("command with select low was not taken");

  chk_select_masks: assert property (
    ctrlPins.chipSelectN |=> !cmdValid)
    else $error("command taken with select high");

  chk_strobe_polarity: assert property (
    runEdge && !ctrlPins.chipSelectN |=>
      cmdStrobes == cmd_s'(~$past({ctrlPins.rowStrobeN, ctrlPins.colStrobeN,
                                   ctrlPins.writeStrobeN})))
    else $error("command strobes not inverted from pins");

  chk_burst_advance: assert property (
    runEdge && burstBusy && !burstStart |=>
      burstColumn == CW'($past(burstColumn) + CW'(1)))
    else $error("burst column did not advance on active edge");

  chk_suspend_enter: assert property (
    s_stall_in_burst |=> powerMode == MODE_SUSPEND)
    else $error("burst stall did not enter suspend");

  chk_suspend_hold: assert property (
    s_stall_in_burst |=> $stable(burstColumn) && $stable(dqOut) && !cmdValid)
    else $error("state moved during clock suspend");

  chk_precharge_pd: assert property (
    awake && !clkEnable && !burstBusy && !refreshReq && allBanksIdle
      |=> powerMode == MODE_PRE_PD)
    else $error("idle banks did not enter precharge power-down");

  chk_active_pd: assert property (
    awake && !clkEnable && !burstBusy && !refreshReq && !allBanksIdle
      |=> powerMode == MODE_ACT_PD)
    else $error("open row did not enter active power-down");

  chk_lowpower_exit: assert property (
    !awake && clkEnable |=> powerMode == MODE_RUN)
    else $error("enable high did not leave low-power mode");

  chk_receivers_off: assert property (
    !awake |-> !receiversOn && !cmdValid ##1 (awake || !cmdValid))
    else $error("receivers active in low-power mode");

  chk_write_mask: assert property (
    runEdge && burstWrite && lowLaneMask |=> !writeKeep[0])
    else $error("masked write lane still stored");

  chk_read_hiz: assert property (
    s_read_masked_low ##1 runEdge |=> !dqOe[0])
    else $error("masked read lane still driven two clocks later");

  chk_edge_active: assert property (
    runEdge |=> edgeActive)
    else $error("enabled edge not flagged active");

  chk_edge_idle: assert property (
    !runEdge |=> !edgeActive)
    else $error("disabled edge flagged active");

  chk_self_refresh: assert property (
    awake && !clkEnable && !burstBusy && refreshReq |=> powerMode == MODE_SELF_REF)
    else $error("refresh with enable low did not enter self refresh");

  chk_stay_running: assert property (
    awake && clkEnable |=> powerMode == MODE_RUN)
    else $error("enable high left run mode");

  chk_exit_quiet: assert property (
    !awake && clkEnable |=> !cmdValid && !edgeActive && $stable(burstColumn))
    else $error("low-power exit edge did work");

  chk_strobes_hold: assert property (
    !(runEdge && !ctrlPins.chipSelectN) |=> $stable(cmdStrobes))
    else $error("command strobes changed without a command");

  chk_write_idle: assert property (
    !runEdge |=> writeKeep == '0)
    else $error("write lane stored on a stopped edge");

  chk_mask_hold: assert property (
    !runEdge |=> $stable(dqOe))
    else $error("drive enables moved on a stopped edge");

  chk_read_drive: assert property (
    s_read_open_low ##1 runEdge |=> dqOe[0])
    else $error("unmasked read lane not driven two clocks later");

  chk_read_hiz_high: assert property (
    s_read_masked_high ##1 runEdge |=> !dqOe[1])
    else $error("masked high read lane still driven");

  chk_write_mask_high: assert property (
    runEdge && burstWrite && highLaneMask |=> !writeKeep[1])
    else $error("masked high write lane still stored");

  chk_dq_capture: assert property (
    runEdge |=> dqOut == $past(coreReadData))
    else $error("output data not updated on active edge");

  chk_burst_restart: assert property (
    runEdge && burstStart |=> burstColumn == '0)
    else $error("burst start did not clear the column");

endmodule

// [sdram_ctrl_pkg.sv]
// Shared constants and types for the SDRAM control-input front end
package sdram_ctrl_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int LANES = 2;
  localparam int DATA_W = 16;
  localparam int COL_W = 10;
  // Clocks from a read-mask sample to the lane's drivers going quiet
  localparam int MASK_LATENCY = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Raw command pins, all active low
  typedef struct packed {
    logic chipSelectN;
    logic rowStrobeN;
    logic colStrobeN;
    logic writeStrobeN;
  } ctrl_s;

  // Registered command strobes, high means asserted
  typedef struct packed {
    logic rowStrobe;
    logic colStrobe;
    logic writeStrobe;
  } cmd_s;

  localparam cmd_s CMD_REFRESH = cmd_s'(3'h6);
  localparam cmd_s CMD_RST = cmd_s'(3'h0);

  // ----------------------------------------------------------------
  // Clock-gating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_SUSPEND = 3'b001,
    MODE_PRE_PD = 3'b010,
    MODE_ACT_PD = 3'b011,
    MODE_SELF_REF = 3'b100
  } power_e;

  localparam power_e MODE_RST = MODE_RUN;

endpackage

// [lane_mask_pipe.sv]
// Per-lane data mask handling: write store enables and delayed read drive enables
`timescale 1ns/1ps

module lane_mask_pipe
  import sdram_ctrl_pkg::*;
#(
  parameter int NUM_LANES = sdram_ctrl_pkg::LANES,
  parameter int LATENCY = sdram_ctrl_pkg::MASK_LATENCY
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Qualifiers
  input wire logic advance,
  input wire logic readActive,
  input wire logic writeActive,
  input wire logic [NUM_LANES-1:0] laneMask,
  // Lane controls
  output logic [NUM_LANES-1:0] writeKeep,
  output logic [NUM_LANES-1:0] driveEnable
);

  // ----------------------------------------------------------------
  // One pipeline per lane
  // ----------------------------------------------------------------
  // The output flop is the last stage, so LATENCY-1 stages precede it
  genvar lane;
  generate
    for (lane = 0; lane < NUM_LANES; lane++) begin : g_lane
      logic [LATENCY-2:0] readPipe;
      logic [LATENCY-2:0] maskPipe;

      // A lane masked during a read goes high impedance LATENCY clocks later
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          readPipe <= '0;
          maskPipe <= '0;
          driveEnable[lane] <= 1'b0;
        end else if (advance) begin
          // Oldest sample falls off the top of each shift register
          readPipe <= (LATENCY-1)'({readPipe, readActive});
          maskPipe <= (LATENCY-1)'({maskPipe, laneMask[lane]});
          driveEnable[lane] <= readPipe[LATENCY-2] & ~maskPipe[LATENCY-2];
        end
      end

      // Write masking takes effect one clock after the mask is sampled
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          writeKeep[lane] <= 1'b0;
        end else if (advance) begin
          writeKeep[lane] <= writeActive & ~laneMask[lane];
        end else begin
          writeKeep[lane] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// [sdram_ctrl_model.sv]
// Controller-side model that forms the command pins
`timescale 1ns/1ps

module sdram_ctrl_model
  import sdram_ctrl_pkg::*;
(
  // Request from the bench
  input wire logic reqValid,
  input wire logic reqSelect,
  input wire sdram_ctrl_pkg::cmd_s reqCmd,
  // Pins toward the device
  output sdram_ctrl_pkg::ctrl_s ctrlPins
);
  // Idle pins stay deselected so nothing is decoded between requests
  always_comb begin
    if (reqValid) begin
      ctrlPins = ctrl_s'({~reqSelect, ~reqCmd});
    end else begin
      ctrlPins = ctrl_s'(4'hF);
    end
  end
endmodule

// [tb_sdram_control_input_decode.sv]
// Self-checking bench for the control-input front end
`timescale 1ns/1ps

module tb_sdram_control_input_decode;
  import sdram_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEnable = 1'b1;
  logic lowLaneMask = 1'b0;
  logic highLaneMask = 1'b0;
  logic allBanksIdle = 1'b1;
  logic burstStart = 1'b0;
  logic burstRead = 1'b0;
  logic burstWrite = 1'b0;
  logic [15:0] coreReadData = 16'h0000;
  logic reqValid = 1'b0;
  logic reqSelect = 1'b0;
  cmd_s reqCmd = CMD_RST;
  ctrl_s ctrlPins;
  logic cmdValid;
  cmd_s cmdStrobes;
  power_e powerMode;
  logic receiversOn;
  logic edgeActive;
  logic [9:0] burstColumn;
  logic [15:0] dqOut;
  logic [1:0] dqOe;
  logic [1:0] writeKeep;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000A393;

  always #2.5 clock = ~clock;

  sdram_ctrl_model i_model (.reqValid(reqValid), .reqSelect(reqSelect), .reqCmd(reqCmd),
    .ctrlPins(ctrlPins));

  sdram_control_input_decode i_dut (.clock(clock), .sys_rst(sys_rst), .clkEnable(clkEnable),
    .ctrlPins(ctrlPins), .lowLaneMask(lowLaneMask), .highLaneMask(highLaneMask),
    .allBanksIdle(allBanksIdle), .burstStart(burstStart), .burstRead(burstRead),
    .burstWrite(burstWrite), .coreReadData(coreReadData), .cmdValid(cmdValid),
    .cmdStrobes(cmdStrobes), .powerMode(powerMode), .receiversOn(receiversOn),
    .edgeActive(edgeActive), .burstColumn(burstColumn), .dqOut(dqOut), .dqOe(dqOe),
    .writeKeep(writeKeep));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Per-lane enable: set only on lanes whose mask is low
  function automatic logic [1:0] lane_on(input logic act, input logic [1:0] mask);
    return {2{act}} & ~mask;
  endfunction

  // Inputs change at the falling edge, outputs are read there too
  task automatic nx();
    @(posedge clock);
    @(negedge clock);
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checked %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Ceiling is far above the roughly 60 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    cmd_s last;
    logic [31:0] r;
    logic [15:0] d;
    logic [1:0] cur;
    logic [1:0] old;
    power_e expMode [3];
    expMode = '{MODE_PRE_PD, MODE_ACT_PD, MODE_SELF_REF};
    repeat (4) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    nx();
    chk("mode", 16'(powerMode), 16'(MODE_RUN));
    chk("rx", 16'(receiversOn), 16'h0001);
    chk("oe", 16'(dqOe), 16'h0000);
    $display("done reset");
    // Every strobe code selected, then random select levels
    last = cmdStrobes;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      reqSelect = (i < 8) ? 1'b1 : r[0];
      reqCmd = cmd_s'(i[2:0]);
      reqValid = 1'b1;
      nx();
      if (reqSelect) begin
        last = cmd_s'(i[2:0]);
      end
      chk("valid", 16'(cmdValid), 16'(reqSelect));
      chk("strobes", 16'(cmdStrobes), 16'(last));
      chk("edge", 16'(edgeActive), 16'h0001);
    end
    reqValid = 1'b0;
    chk("mode", 16'(powerMode), 16'(MODE_RUN));
    $display("done commands");
    burstStart = 1'b1;
    burstRead = 1'b1;
    nx();
    chk("col", 16'(burstColumn), 16'h0000);
    burstStart = 1'b0;
    for (int n = 1; n <= 5; n++) begin
      r = rnd();
      coreReadData = r[15:0];
      d = coreReadData;
      nx();
      chk("col", 16'(burstColumn), 16'(n));
      chk("dq", dqOut, d);
    end
    clkEnable = 1'b0;
    reqValid = 1'b1;
    reqSelect = 1'b1;
    r = rnd();
    coreReadData = r[15:0];
    nx();
    chk("mode", 16'(powerMode), 16'(MODE_SUSPEND));
    nx();
    chk("col", 16'(burstColumn), 16'h0005);
    chk("dq", dqOut, d);
    chk("valid", 16'(cmdValid), 16'h0000);
    chk("edge", 16'(edgeActive), 16'h0000);
    reqValid = 1'b0;
    clkEnable = 1'b1;
    nx();
    chk("col", 16'(burstColumn), 16'h0006);
    burstRead = 1'b0;
    $display("done burst");
    for (int k = 0; k < 3; k++) begin
      allBanksIdle = (k != 1);
      reqValid = (k == 2);
      reqCmd = CMD_REFRESH;
      clkEnable = 1'b0;
      nx();
      chk("mode", 16'(powerMode), 16'(expMode[k]));
      chk("rx", 16'(receiversOn), 16'h0000);
      reqValid = 1'b1;
      reqCmd = cmd_s'(3'h4);
      nx();
      chk("valid", 16'(cmdValid), 16'h0000);
      clkEnable = 1'b1;
      nx();
      chk("mode", 16'(powerMode), 16'(MODE_RUN));
      chk("valid", 16'(cmdValid), 16'h0000);
      chk("edge", 16'(edgeActive), 16'h0000);
      nx();
      chk("valid", 16'(cmdValid), 16'h0001);
      chk("edge", 16'(edgeActive), 16'h0001);
    end
    $display("done power");
    // Select held high: masks keep working while commands are ignored
    reqValid = 1'b1;
    reqSelect = 1'b0;
    old = 2'b00;
    for (int i = 0; i < 16; i++) begin
      r = (i == 0) ? 32'h00000006 : rnd();
      burstWrite = r[0];
      burstRead = r[1];
      lowLaneMask = r[2];
      highLaneMask = r[3];
      cur = lane_on(r[1], r[3:2]);
      nx();
      chk("keep", 16'(writeKeep), 16'(lane_on(r[0], r[3:2])));
      chk("oe", 16'(dqOe), 16'(old));
      chk("valid", 16'(cmdValid), 16'h0000);
      old = cur;
    end
    $display("done masks");
    conclude();
  end
endmodule
